// [logic/sfdp_params.svh]
// Purpose: constants for the parameter table link and its far-end reader
// Assumes: byte addresses are the table's own byte offsets
// Notes: table words stored low byte first
`ifndef SFDP_PARAMS_SVH
`define SFDP_PARAMS_SVH
`define CMD_PARAM_READ 8'h5a
`define CMD_STATUS_READ 8'h05
`define BLANK_BYTE 8'hff
`define TBL_BASE 8'h60
`define TBL_LAST 8'hdf
`define BUSY_BIT 0
`define LINK_DIV 4'h3
`define DUMMY_BITS 6'h08
`endif

// [logic/sfdp_pkg.sv]
// Purpose: shared types for the parameter table link
// Assumes: nothing beyond the params header
// Notes: width enum covers the three uniform bus widths and the mixed one
package sfdp_pkg;
   typedef enum logic [1:0] {
      WIDTH_SINGLE = 2'b00,
      WIDTH_DUAL = 2'b01,
      WIDTH_QUAD = 2'b10,
      WIDTH_MIXED = 2'b11
   } bus_width_t;
   typedef logic [7:0] byte_t;
endpackage

// [logic/sfdp_link_if.sv]
// Purpose: serial link between table device and host reader
// Assumes: single data line per direction in this build
// Notes: host drives clock and select
`timescale 1ns/1ps
`default_nettype none
interface sfdp_link_if;
   logic sck;
   logic csN;
   logic mosi;
   logic miso;
   sfdp_pkg::bus_width_t width;
   modport dev (input sck, input csN, input mosi, input width, output miso);
   modport host (output sck, output csN, output mosi, output width, input miso);
endinterface
`default_nettype wire

// [logic/sfdp_table_rom.sv]
// Purpose: constant byte lookup of the upper parameter words
// Assumes: byte address of the table
// Notes: pure combinational lookup
`timescale 1ns/1ps
`default_nettype none
`include "sfdp_params.svh"
module sfdp_table_rom (
   input wire logic [7:0] addr,
   output logic [7:0] data
);
   import sfdp_pkg::*;
   always_comb begin
      unique case (addr)
         8'h60: data = 8'h7a;
         8'h61: data = 8'h75;
         8'h62: data = 8'h7a;
         8'h63: data = 8'h75;
         8'h5f: data = 8'h35;
         8'h64: data = 8'hf7;
         8'h65: data = 8'hb3;
         8'h66: data = 8'hd5;
         8'h67: data = 8'h5c;
         8'h68: data = 8'h19;
         8'h69: data = 8'hf6;
         8'h6a: data = 8'h4d;
         8'h6b: data = 8'hff;
         8'h6c: data = 8'he9;
         8'h6d: data = 8'h50;
         8'h6e: data = 8'hf9;
         8'h6f: data = 8'h85;
         8'hc0: data = 8'hff;
         8'hc1: data = 8'h8e;
         8'hc2: data = 8'hf0;
         8'hc3: data = 8'hff;
         8'hc4: data = 8'h21;
         8'hc5: data = 8'h5c;
         8'hc6: data = 8'hdc;
         8'hc7: data = 8'hff;
         8'hd6: data = 8'h77;
         8'hd7: data = 8'h64;
         default: data = `BLANK_BYTE;
      endcase
   end
endmodule
`default_nettype wire

// [logic/sfdp_device.sv]
// Function
// - suspend 75h and resume 7Ah advertised
// - suspend word bit 31 reads zero
// - busy polled via status bit 0
// - power-down release delay count 10011b unit 01b
// - power-down entry opcode B9h, supported
// - power-down release opcode ABh
// - quad exit by FFh or soft reset
// - quad entry by enable bit then 38h
// - continuous read kept while mode Axh
// - quad enable is status-2 bit 1
// - soft reset 66h then 99h
// - leave 4-byte mode with E9h
// - enter 4-byte mode with B7h
// - extended address register C8h/C5h
// - status-1 mixed bits, 06h and 50h
// - 4-byte opcode support set advertised
// - 4-byte erase opcodes 21h 5Ch DCh
// - wrap read 77h, length code 64h
// - unused table bytes read FFh
// - table read only in uniform width
// - host sends 8 zero dummy bits straight after the address, no mode bits
// Purpose: device end answering parameter reads and status polls
// Assumes: runs on the link clock; framing reset by select high, busy sync and reply by nrst
// Notes: mode 0 framing, data out on falling edge
`timescale 1ns/1ps
`default_nettype none
`include "sfdp_params.svh"
module sfdp_device (
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic busyIn,
   sfdp_link_if.dev link
);
   import sfdp_pkg::*;
   typedef enum logic [1:0] {
      S_CMD = 2'b00,
      S_ADDR = 2'b01,
      S_DATA = 2'b10,
      S_IDLE = 2'b11
   } dev_state_t;
   dev_state_t state_q;
   logic [5:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] addr_q;
   logic [7:0] outByte;
   logic isStatus_q;
   logic miso_q;
   logic [7:0] romData;
   logic [1:0] busySync_q;
   logic [7:0] shNext;
   assign shNext = {sh_q[6:0], link.mosi};
   sfdp_table_rom rom (.addr(addr_q), .data(romData));
   always_ff @(posedge link.sck or negedge nrst) begin
      if (!nrst) begin
         busySync_q <= 2'b00;
      end else if (clkEn) begin
         busySync_q <= {busySync_q[0], busyIn};
      end
   end
   // select high restarts framing; the clock stops between frames
   always_ff @(posedge link.sck or posedge link.csN) begin
      if (link.csN) begin
         state_q <= S_CMD;
         cnt_q <= 6'h00;
         sh_q <= 8'h00;
         addr_q <= 8'h00;
         isStatus_q <= 1'b0;
      end else if (clkEn) begin
         sh_q <= shNext;
         cnt_q <= cnt_q + 6'h01;
         unique case (state_q)
            S_CMD: begin
               if (cnt_q == 6'h07) begin
                  cnt_q <= 6'h00;
                  if (shNext == `CMD_STATUS_READ) begin
                     isStatus_q <= 1'b1;
                     state_q <= S_DATA;
                  end else if (shNext == `CMD_PARAM_READ &&
                               link.width != WIDTH_MIXED) begin
                     state_q <= S_ADDR;
                  end else begin
                     state_q <= S_IDLE;
                  end
               end
            end
            S_ADDR: begin
               // 24 address bits, then dummy bits; low byte kept
               if (cnt_q == 6'h17) begin
                  addr_q <= shNext;
               end
               if (cnt_q == 6'h17 + `DUMMY_BITS) begin
                  cnt_q <= 6'h00;
                  state_q <= S_DATA;
               end
            end
            S_DATA: begin
               if (cnt_q == 6'h07) begin
                  cnt_q <= 6'h00;
                  addr_q <= addr_q + 8'h01;
               end
            end
            S_IDLE: begin
               cnt_q <= 6'h00;
            end
         endcase
      end
   end
   always_comb begin
      outByte = isStatus_q ? {7'h00, busySync_q[1]} : romData;
   end
   always_ff @(negedge link.sck or negedge nrst) begin
      if (!nrst) begin
         miso_q <= 1'b1;
      end else if (clkEn) begin
         if (state_q == S_DATA) begin
            miso_q <= outByte[3'h7 - cnt_q[2:0]];
         end else begin
            miso_q <= 1'b1;
         end
      end
   end
   // the last fall of a frame preloads the next bit; deselect must still show idle high
   assign link.miso = miso_q | link.csN;
endmodule
`default_nettype wire

// [logic/sfdp_host.sv]
// Purpose: host end issuing one parameter or status byte read per request
// Assumes: sys_clk 20 MHz, link clock divided from it
// Notes: one byte per frame keeps the state machine small
`timescale 1ns/1ps
`default_nettype none
`include "sfdp_params.svh"
module sfdp_host (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic reqValid,
   input wire logic reqStatus,
   input wire logic [7:0] reqAddr,
   output logic reqBusy,
   output logic rspValid,
   output logic [7:0] rspData,
   sfdp_link_if.host link
);
   import sfdp_pkg::*;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SHIFT = 2'b01,
      H_DONE = 2'b10
   } host_state_t;
   host_state_t state_q;
   logic [3:0] div_q;
   logic sck_q;
   logic csN_q;
   logic [6:0] bit_q;
   logic [6:0] last_q;
   logic [39:0] tx_q;
   logic [7:0] rx_q;
   logic reqBusy_q;
   logic rspValid_q;
   logic [7:0] rspData_q;
   logic [1:0] misoSync_q;
   // reply line comes from the link clock domain; two flops before use
   // the sample still lands: the reply moved four cycles before each rise
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         misoSync_q <= 2'b11;
      end else if (clkEn) begin
         misoSync_q <= {misoSync_q[0], link.miso};
      end
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= H_IDLE;
         div_q <= 4'h0;
         sck_q <= 1'b0;
         csN_q <= 1'b1;
         bit_q <= 7'h00;
         last_q <= 7'h00;
         tx_q <= 40'h0;
         rx_q <= 8'h00;
         reqBusy_q <= 1'b0;
         rspValid_q <= 1'b0;
         rspData_q <= 8'h00;
      end else if (clkEn) begin
         rspValid_q <= 1'b0;
         unique case (state_q)
            H_IDLE: begin
               if (reqValid) begin
                  reqBusy_q <= 1'b1;
                  csN_q <= 1'b0;
                  div_q <= 4'h0;
                  bit_q <= 7'h00;
                  state_q <= H_SHIFT;
                  if (reqStatus) begin
                     tx_q <= {`CMD_STATUS_READ, 32'h0};
                     last_q <= 7'h0f;
                  end else begin
                     tx_q <= {`CMD_PARAM_READ, 16'h0000, reqAddr, 8'h00};
                     last_q <= 7'h2f;
                  end
               end
            end
            H_SHIFT: begin
               div_q <= div_q + 4'h1;
               if (div_q == `LINK_DIV) begin
                  div_q <= 4'h0;
                  sck_q <= ~sck_q;
                  if (!sck_q) begin
                     rx_q <= {rx_q[6:0], misoSync_q[1]};
                  end else begin
                     tx_q <= {tx_q[38:0], 1'b0};
                     bit_q <= bit_q + 7'h01;
                     if (bit_q == last_q) begin
                        state_q <= H_DONE;
                     end
                  end
               end
            end
            H_DONE: begin
               csN_q <= 1'b1;
               reqBusy_q <= 1'b0;
               rspValid_q <= 1'b1;
               rspData_q <= rx_q;
               state_q <= H_IDLE;
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end
   assign link.sck = sck_q;
   assign link.csN = csN_q;
   assign link.mosi = tx_q[39];
   assign link.width = WIDTH_SINGLE;
   assign reqBusy = reqBusy_q;
   assign rspValid = rspValid_q;
   assign rspData = rspData_q;
endmodule
`default_nettype wire

// [tb/sfdp_link_assertions.sv]
// Purpose: wire checks on the parameter table link
// Assumes: sys_clk samples the host-made link clock
// Notes: sck is sys_clk/8, so each level lasts four samples
`timescale 1ns/1ps
`default_nettype none
module sfdp_link_assertions (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic csN,
   input wire logic mosi,
   input wire logic miso,
   input wire sfdp_pkg::bus_width_t width
);
   import sfdp_pkg::*;
   logic sckQ;
   logic [6:0] riseCnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) sckQ <= 1'h0;
      else sckQ <= sck;
   end
   // counts link clock rises per frame, cleared while deselected
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) riseCnt <= 7'h00;
      else if (csN) riseCnt <= 7'h00;
      else if (sck && !sckQ) riseCnt <= riseCnt + 7'h01;
   end
   sequence halfHigh;
      sck [*4] ##1 !sck;
   endsequence
   sequence halfLow;
      !sck [*3];
   endsequence
   a_width_single: assert property (width == WIDTH_SINGLE)
      else $error("link width not single");
   a_sck_high_phase: assert property ($rose(sck) |-> halfHigh)
      else $error("link clock high phase wrong");
   a_sck_low_phase: assert property ($fell(sck) |-> halfLow)
      else $error("link clock low phase short");
   a_sck_idle_low: assert property (csN && $past(csN) |-> !sck)
      else $error("link clock runs while deselected");
   a_miso_idle_high: assert property (csN && $past(csN) |-> miso)
      else $error("reply line not idle high");
   a_miso_on_fall: assert property ($changed(miso) && !csN |-> !sck)
      else $error("reply changed outside clock low");
   a_mosi_hold_high: assert property (sck && $past(sck) && !csN |-> $stable(mosi))
      else $error("command line moved while clock high");
   a_frame_length: assert property ($rose(csN) |-> riseCnt == 7'h10 || riseCnt == 7'h30)
      else $error("frame bit count wrong");
endmodule
`default_nettype wire

// [tb/flash_parameter_table_rom_tb_top.sv]
// Purpose: reads the upper table through host and device ends
// Assumes: both ends joined by one link interface
// Notes: expected bytes are decoded by hand from the field layout
`timescale 1ns/1ps
`default_nettype none
module flash_parameter_table_rom_tb_top;
   import sfdp_pkg::*;
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic busyIn = 1'h0;
   logic reqValid = 1'h0;
   logic reqStatus = 1'h0;
   logic [7:0] reqAddr = 8'h00;
   logic reqBusy;
   logic rspValid;
   logic [7:0] rspData;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;
   sfdp_link_if link ();
   sfdp_device i_sfdp_device (.nrst(nrst), .clkEn(1'h1), .busyIn(busyIn), .link(link.dev));
   sfdp_host i_sfdp_host (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'h1), .reqValid(reqValid),
      .reqStatus(reqStatus), .reqAddr(reqAddr), .reqBusy(reqBusy), .rspValid(rspValid),
      .rspData(rspData), .link(link.host));
   sfdp_link_assertions i_sfdp_link_assertions (.sys_clk(sys_clk), .nrst(nrst),
      .sck(link.sck), .csN(link.csN), .mosi(link.mosi), .miso(link.miso), .width(link.width));
   always #25 sys_clk = ~sys_clk;
   // 34 frames, 32 of ~390 cycles and two status frames of ~130, so 30000 leaves ample margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         error_cnt++;
         conclude();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // request held one cycle only: the host takes it in idle and ignores it while busy
   task automatic xfer(input logic stat, input logic [7:0] addr, output logic [7:0] got);
      int n;
      @(negedge sys_clk);
      reqStatus = stat;
      reqAddr = addr;
      reqValid = 1'h1;
      @(negedge sys_clk);
      reqValid = 1'h0;
      check({7'h00, reqBusy}, 8'h01);
      n = 0;
      while (rspValid !== 1'h1 && n < 1000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 1000) error_cnt++;
      got = rspData;
      check({7'h00, reqBusy}, 8'h00);
   endtask
   task automatic t_upper();
      logic [7:0] e [16] = '{8'h7a, 8'h75, 8'h7a, 8'h75, 8'hf7, 8'hb3, 8'hd5, 8'h5c,
         8'h19, 8'hf6, 8'h4d, 8'hff, 8'he9, 8'h50, 8'hf9, 8'h85};
      logic [7:0] g;
      for (int i = 0; i < 16; i++) begin
         xfer(1'h0, 8'h60 + 8'(i), g);
         check(g, e[i]);
      end
      $display("upper words done");
   endtask
   task automatic t_opset();
      logic [7:0] a [10] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7,
         8'hd6, 8'hd7};
      logic [7:0] e [10] = '{8'hff, 8'h8e, 8'hf0, 8'hff, 8'h21, 8'h5c, 8'hdc, 8'hff,
         8'h77, 8'h64};
      logic [7:0] g;
      for (int i = 0; i < 10; i++) begin
         xfer(1'h0, a[i], g);
         check(g, e[i]);
      end
      $display("opcode set done");
   endtask
   task automatic t_blank();
      logic [7:0] a [5] = '{8'h00, 8'h70, 8'hc8, 8'hdc, 8'hdf};
      logic [7:0] g;
      for (int i = 0; i < 5; i++) begin
         xfer(1'h0, a[i], g);
         check(g, 8'hff);
      end
      xfer(1'h0, 8'h5f, g);
      check(g & 8'h80, 8'h00);
      $display("blank fill done");
   endtask
   task automatic t_busy();
      logic [7:0] g;
      @(negedge sys_clk);
      busyIn = 1'h1;
      xfer(1'h1, 8'h00, g);
      check(g & 8'h01, 8'h01);
      @(negedge sys_clk);
      busyIn = 1'h0;
      xfer(1'h1, 8'h00, g);
      check(g & 8'h01, 8'h00);
      $display("busy poll done");
   endtask
   task automatic conclude();
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      nrst = 1'h1;
      t_upper();
      t_opset();
      t_blank();
      t_busy();
      conclude();
   end
endmodule
`default_nettype wire
